// file: verilog/psq_defs.svh
`ifndef PSQ_DEFS_SVH
`define PSQ_DEFS_SVH

// Program counter widths of the two variants
`define PSQ_PC_W_SMALL       10
`define PSQ_PC_W_LARGE       11

// Return-address stack depths of the two variants
`define PSQ_DEPTH_SMALL      4
`define PSQ_DEPTH_LARGE      8

// Instruction word widths of the two variants
`define PSQ_INSTR_W_SMALL    14
`define PSQ_INSTR_W_LARGE    15

// Width of the software-visible low byte and the page it selects within
`define PSQ_LOW_BYTE_W       8

// Address taken after reset
`define PSQ_RESET_VECTOR     0

// Phases per instruction cycle
`define PSQ_PHASES           4

`endif

// file: verilog/psq_pkg.sv
package psq_pkg;

   // One instruction cycle is four system clocks, one per phase
   typedef enum logic [1:0] {
      PSQ_T1,
      PSQ_T2,
      PSQ_T3,
      PSQ_T4
   } psq_phase_t;

   // Flow-control class reported by the execute unit for the current instruction
   typedef enum logic [2:0] {
      PSQ_OP_NONE,
      PSQ_OP_JUMP,
      PSQ_OP_CALL,
      PSQ_OP_RETURN_SUB,
      PSQ_OP_RETURN_INT,
      PSQ_OP_SKIP,
      PSQ_OP_PC_LOW_WR
   } psq_op_t;

endpackage : psq_pkg

// file: verilog/psq_stack.sv
`timescale 1ns/10ps
`include "psq_defs.svh"

module psq_stack #(
   parameter int DEPTH = `PSQ_DEPTH_SMALL,
   parameter int WIDTH = `PSQ_PC_W_SMALL
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Commands, at most one per cycle
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   // State
   output logic      [WIDTH-1:0] top_data,
   output logic                  full,
   output logic                  empty
);

   localparam int PTR_W = $clog2(DEPTH);

   generate
      if ((DEPTH < 2) || ((1 << PTR_W) != DEPTH)) begin : g_bad_depth
         $error("psq_stack: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   // Entries are never visible to software; only the sequencer touches them
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] ptr_reg;
   logic [PTR_W:0]   count_reg;
   logic             full_reg;
   logic             empty_reg;

   function automatic logic [PTR_W-1:0] ptr_dec(input logic [PTR_W-1:0] p);
      ptr_dec = p - 1'b1;
   endfunction : ptr_dec

   assign top_data = mem[ptr_dec(ptr_reg)];
   assign full     = full_reg;
   assign empty    = empty_reg;

   // Circular storage: a push when full overwrites the oldest saved entry
   always_ff @(posedge clk) begin
      if (push) begin
         mem[ptr_reg] <= push_data; // [RULE17]
      end
   end

   // Pointer starts at the top of the stack
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_reg   <= '0; // [RULE14]
         count_reg <= '0;
         full_reg  <= 1'b0;
         empty_reg <= 1'b1;
      end else if (push) begin
         ptr_reg   <= ptr_reg + 1'b1;
         empty_reg <= 1'b0;
         if (count_reg >= (PTR_W+1)'(DEPTH - 1)) begin
            count_reg <= (PTR_W+1)'(DEPTH); // [RULE16]
            full_reg  <= 1'b1;
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end else if (pop && !empty_reg) begin
         ptr_reg   <= ptr_dec(ptr_reg);
         count_reg <= count_reg - 1'b1;
         full_reg  <= 1'b0;
         empty_reg <= (count_reg == (PTR_W+1)'(1));
      end
   end

endmodule : psq_stack

// file: verilog/psq_sequencer.sv
`timescale 1ns/10ps
`include "psq_defs.svh"

// Overview of operation
// [RULE1] Four non-overlapping phases from the system clock make one instruction cycle.
// [RULE2] Counter advances at phase one start; fetch happens in phase one, execute after.
// [RULE3] Fetch of next instruction overlaps execution, one instruction per cycle.
// [RULE4] Jumps and calls take two instruction cycles: address, then branch.
// [RULE5] Counter increments by one unless the instruction branches elsewhere.
// [RULE6] Jump, call, interrupt and reset load their destination straight into the counter.
// [RULE7] Taken conditional skip discards the fetched instruction and inserts a dummy cycle.
// [RULE8] Counter is 10 or 11 bits; only its low 8 bits are software visible.
// [RULE9] Low byte readable and writable; a write jumps within the current 256-word page.
// [RULE10] Writing the low byte inserts a dummy cycle to pre-fetch the target.
// [RULE11] Stack holds only counter values, hidden from software, pointer included.
// [RULE12] Call or interrupt acknowledge pushes the counter onto the stack.
// [RULE13] Return from subroutine or interrupt restores the counter from the stack.
// [RULE14] Reset sets the stack pointer to the top of the stack.
// [RULE15] Full stack holds back interrupt acknowledge until a return frees a level.
// [RULE16] A call on a full stack still executes and overflows the stack.
// [RULE17] Overflow loses the earliest saved counter value.
// [RULE18] Stack depth is 4 levels on the small variant, 8 on the large one.
// [RULE19] After reset execution begins at address zero.

module psq_sequencer
   import psq_pkg::*;
#(
   parameter int PC_W    = `PSQ_PC_W_SMALL,
   parameter int DEPTH   = `PSQ_DEPTH_SMALL,
   parameter int INSTR_W = `PSQ_INSTR_W_SMALL
) (
   // Clock and reset
   input  wire logic                       CLOCK,
   input  wire logic                       RST_B,
   // Program memory fetch port
   output logic      [PC_W-1:0]            FETCH_ADDR,
   output logic                            FETCH_EN,
   input  wire logic [INSTR_W-1:0]         INSTR_DATA,
   // Instruction handed to the execute unit
   output psq_phase_t                      PHASE,
   output logic      [INSTR_W-1:0]         INSTR_WORD,
   output logic                            INSTR_VALID,
   output logic      [PC_W-1:0]            EXEC_ADDR,
   // Flow control from the execute unit, sampled in the last phase
   input  wire psq_op_t                    CTRL_OP,
   input  wire logic [PC_W-1:0]            CTRL_TARGET,
   input  wire logic [`PSQ_LOW_BYTE_W-1:0] CTRL_LOW_BYTE,
   // Software view of the counter low byte
   output logic      [`PSQ_LOW_BYTE_W-1:0] PC_LOW_BYTE,
   // Interrupt controller
   input  wire logic                       INT_REQ,
   input  wire logic [PC_W-1:0]            INT_VECTOR,
   output logic                            INT_ACK,
   // Stack status
   output logic                            STACK_FULL,
   output logic                            STACK_OVERFLOW
);

   generate
      if ((PC_W != `PSQ_PC_W_SMALL) && (PC_W != `PSQ_PC_W_LARGE)) begin : g_bad_pc_w
         $error("psq_sequencer: PC_W must be 10 or 11");
      end
      if ((DEPTH != `PSQ_DEPTH_SMALL) && (DEPTH != `PSQ_DEPTH_LARGE)) begin : g_bad_depth
         $error("psq_sequencer: DEPTH must be 4 or 8");
      end
      if (INSTR_W < 1) begin : g_bad_instr_w
         $error("psq_sequencer: INSTR_W must be positive");
      end
   endgenerate

   localparam int PAGE_W = PC_W - `PSQ_LOW_BYTE_W;

   // Phase state
   psq_phase_t                      phase_reg;
   psq_phase_t                      phase_next;

   // Fetch side
   logic       [PC_W-1:0]           pc_reg;
   logic       [PC_W-1:0]           fetch_addr_reg;
   logic                            fetch_en_reg;
   logic       [INSTR_W-1:0]        fetch_buf_reg;

   // Execute side
   logic       [INSTR_W-1:0]        instr_word_reg;
   logic                            instr_valid_reg;
   logic       [PC_W-1:0]           exec_addr_reg;
   logic       [`PSQ_LOW_BYTE_W-1:0] pc_low_byte_reg;

   // Strobes
   logic                            int_ack_reg;
   logic                            overflow_reg;
   logic                            boot_reg;

   // Decision made at the last phase of each instruction cycle
   psq_op_t                         op_eff;
   logic                            at_t4;
   logic                            take_int;
   logic                            flush;
   logic                            stk_push;
   logic                            stk_pop;
   logic       [PC_W-1:0]           stk_push_data;
   logic       [PC_W-1:0]           next_fetch;

   // Stack
   logic       [PC_W-1:0]           stk_top;
   logic                            stk_full;
   logic                            stk_empty;

   // Page-relative target: the page of the executing instruction stays, low byte replaced
   function automatic logic [PC_W-1:0] page_jump(input logic [PC_W-1:0]            base,
                                                 input logic [`PSQ_LOW_BYTE_W-1:0] low);
      page_jump = {base[PC_W-1 -: PAGE_W], low};
   endfunction : page_jump

   // Return-address stack, outside data and program space
   psq_stack #(
      .DEPTH     (DEPTH),
      .WIDTH     (PC_W)
   ) u_stack (
      .clk       (CLOCK),
      .rst_b     (RST_B),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data (stk_push_data),
      .top_data  (stk_top),
      .full      (stk_full),
      .empty     (stk_empty)
   ); // [RULE11] [RULE18]

   // Phase counter; each phase lasts one system clock
   always_comb begin
      case (phase_reg)
         PSQ_T1:  phase_next = PSQ_T2;
         PSQ_T2:  phase_next = PSQ_T3;
         PSQ_T3:  phase_next = PSQ_T4;
         PSQ_T4:  phase_next = PSQ_T1;
         default: phase_next = PSQ_T1;
      endcase
   end

   // Reset lands in the last phase so the very first edge starts a fetch cycle
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         phase_reg <= PSQ_T4;
      end else begin
         phase_reg <= phase_next; // [RULE1]
      end
   end

   // Flow-control decision; a dummy cycle never reports an operation
   always_comb begin
      at_t4         = (phase_reg == PSQ_T4);
      op_eff        = instr_valid_reg ? CTRL_OP : PSQ_OP_NONE;
      take_int      = 1'b0;
      // The cycle leaving reset is a dummy, so address zero is the first to execute
      flush         = boot_reg; // [RULE19]
      stk_push      = 1'b0;
      stk_pop       = 1'b0;
      stk_push_data = fetch_addr_reg;
      next_fetch    = pc_reg; // [RULE5]
      case (op_eff)
         PSQ_OP_JUMP: begin
            next_fetch = CTRL_TARGET; // [RULE6]
            flush      = 1'b1; // [RULE4]
         end
         PSQ_OP_CALL: begin
            // Return address is the word fetched behind the call
            stk_push   = at_t4; // [RULE12] [RULE16]
            next_fetch = CTRL_TARGET; // [RULE6]
            flush      = 1'b1; // [RULE4]
         end
         PSQ_OP_RETURN_SUB, PSQ_OP_RETURN_INT: begin
            stk_pop    = at_t4 && !stk_empty;
            next_fetch = stk_top; // [RULE13]
            flush      = 1'b1;
         end
         PSQ_OP_SKIP: begin
            flush      = 1'b1; // [RULE7]
         end
         PSQ_OP_PC_LOW_WR: begin
            next_fetch = page_jump(exec_addr_reg, CTRL_LOW_BYTE); // [RULE9]
            flush      = 1'b1; // [RULE10]
         end
         default: begin
            // Interrupts enter only after a plain instruction or a dummy cycle, never onto a full stack
            if (INT_REQ && !stk_full && !boot_reg) begin // [RULE15]
               take_int   = at_t4;
               stk_push   = at_t4; // [RULE12]
               next_fetch = INT_VECTOR; // [RULE6]
               flush      = 1'b1;
            end
         end
      endcase
   end

   // Fetch address moves at the start of phase one
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         fetch_addr_reg <= PC_W'(`PSQ_RESET_VECTOR); // [RULE19]
      end else if (at_t4) begin
         fetch_addr_reg <= next_fetch; // [RULE2]
      end
   end

   // Program counter runs one word ahead of the fetch address
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pc_reg <= PC_W'(`PSQ_RESET_VECTOR); // [RULE19]
      end else if (at_t4) begin
         pc_reg <= next_fetch + 1'b1; // [RULE2] [RULE5]
      end
   end

   // Fetch strobe covers phase one only
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         fetch_en_reg <= 1'b0;
      end else begin
         fetch_en_reg <= at_t4; // [RULE2]
      end
   end

   // Memory word is taken at the end of phase one
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         fetch_buf_reg <= '0;
      end else if (phase_reg == PSQ_T1) begin
         fetch_buf_reg <= INSTR_DATA;
      end
   end

   // Fetched word becomes the executing one while the next is fetched
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         instr_word_reg <= '0;
      end else if (at_t4) begin
         instr_word_reg <= fetch_buf_reg; // [RULE3]
      end
   end

   // A flushed word still reports its address, but runs as a dummy
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         instr_valid_reg <= 1'b0;
      end else if (at_t4) begin
         instr_valid_reg <= !flush; // [RULE7] [RULE10]
      end
   end

   // Address of the executing word
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         exec_addr_reg <= '0;
      end else if (at_t4) begin
         exec_addr_reg <= fetch_addr_reg; // [RULE3]
      end
   end

   // Marks the cycle leaving reset; nothing executes or interrupts in it
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         boot_reg <= 1'b1;
      end else if (at_t4) begin
         boot_reg <= 1'b0; // [RULE19]
      end
   end

   // Low byte seen by software tracks the instruction in execution
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pc_low_byte_reg <= '0;
      end else if (at_t4) begin
         pc_low_byte_reg <= fetch_addr_reg[`PSQ_LOW_BYTE_W-1:0]; // [RULE8] [RULE9]
      end
   end

   // Acknowledge pulse, one clock, on the edge the vector is loaded
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         int_ack_reg <= 1'b0;
      end else begin
         int_ack_reg <= take_int; // [RULE15]
      end
   end

   // Overflow pulse; only a call can reach it since interrupts wait for room
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         overflow_reg <= 1'b0;
      end else begin
         overflow_reg <= stk_push && stk_full; // [RULE16] [RULE17]
      end
   end

   // Outputs
   assign FETCH_ADDR     = fetch_addr_reg;
   assign FETCH_EN       = fetch_en_reg;
   assign PHASE          = phase_reg;
   assign INSTR_WORD     = instr_word_reg;
   assign INSTR_VALID    = instr_valid_reg;
   assign EXEC_ADDR      = exec_addr_reg;
   assign PC_LOW_BYTE    = pc_low_byte_reg;
   assign INT_ACK        = int_ack_reg;
   assign STACK_FULL     = stk_full;
   assign STACK_OVERFLOW = overflow_reg;

endmodule : psq_sequencer

// file: verification/psq_sequencer_properties.sv
`timescale 1ns/10ps
module psq_seq_props
   import psq_pkg::*;
#(
   parameter int PC_W = 10
) (
   // Clock and reset
   input wire logic            CLOCK,
   input wire logic            RST_B,
   // Watched ports
   input wire logic [PC_W-1:0] FETCH_ADDR,
   input wire logic            FETCH_EN,
   input wire psq_phase_t      PHASE,
   input wire logic            INSTR_VALID,
   input wire logic [PC_W-1:0] EXEC_ADDR,
   input wire psq_op_t         CTRL_OP,
   input wire logic [PC_W-1:0] CTRL_TARGET,
   input wire logic [7:0]      CTRL_LOW_BYTE,
   input wire logic            INT_REQ,
   input wire logic [PC_W-1:0] INT_VECTOR,
   input wire logic            INT_ACK,
   input wire logic            STACK_FULL,
   input wire logic            STACK_OVERFLOW
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   // Flow ops only count at the end of a real instruction
   wire logic t4v = PHASE == PSQ_T4 && INSTR_VALID;

   a_phase_order: assert property (PHASE == PSQ_T1 |-> FETCH_EN ##1 (PHASE == PSQ_T2 && !FETCH_EN)
      ##1 (PHASE == PSQ_T3 && !FETCH_EN) ##1 (PHASE == PSQ_T4 && !FETCH_EN) ##1 PHASE == PSQ_T1) else $error("bad phase");
   a_fetch_hold: assert property (PHASE != PSQ_T4 |=> $stable(FETCH_ADDR)) else $error("fetch moved");
   a_seq_next: assert property (t4v && CTRL_OP == PSQ_OP_NONE && !INT_REQ |=> INSTR_VALID
      && FETCH_ADDR == PC_W'($past(FETCH_ADDR) + 1)) else $error("no increment");
   a_branch_load: assert property (t4v && CTRL_OP inside {PSQ_OP_JUMP, PSQ_OP_CALL} |=> !INSTR_VALID
      && FETCH_ADDR == $past(CTRL_TARGET)) else $error("target not loaded");
   a_skip_dummy: assert property (t4v && CTRL_OP == PSQ_OP_SKIP |=> !INSTR_VALID
      && FETCH_ADDR == PC_W'($past(FETCH_ADDR) + 1)) else $error("skip not flushed");
   a_low_jump: assert property (t4v && CTRL_OP == PSQ_OP_PC_LOW_WR |=> !INSTR_VALID
      && FETCH_ADDR[7:0] == $past(CTRL_LOW_BYTE) && FETCH_ADDR >> 8 == $past(EXEC_ADDR) >> 8) else $error("page jump");
   a_ack_cause: assert property (INT_ACK |-> PHASE == PSQ_T1 && !INSTR_VALID && $past(INT_REQ)
      && !$past(STACK_FULL) && FETCH_ADDR == $past(INT_VECTOR)) else $error("stray ack");
   a_full_block: assert property (PHASE == PSQ_T4 && STACK_FULL |=> !INT_ACK) else $error("ack when full");
   a_call_ovf: assert property (t4v && CTRL_OP == PSQ_OP_CALL && STACK_FULL |=>
      STACK_OVERFLOW && STACK_FULL) else $error("no overflow");
   a_ovf_cause: assert property (STACK_OVERFLOW |-> $past(CTRL_OP) == PSQ_OP_CALL && $past(STACK_FULL))
      else $error("stray overflow");
endmodule : psq_seq_props

bind psq_sequencer psq_seq_props #(.PC_W(PC_W)) i_psq_seq_props (.CLOCK(CLOCK), .RST_B(RST_B),
   .FETCH_ADDR(FETCH_ADDR), .FETCH_EN(FETCH_EN), .PHASE(PHASE), .INSTR_VALID(INSTR_VALID), .EXEC_ADDR(EXEC_ADDR),
   .CTRL_OP(CTRL_OP), .CTRL_TARGET(CTRL_TARGET), .CTRL_LOW_BYTE(CTRL_LOW_BYTE), .INT_REQ(INT_REQ),
   .INT_VECTOR(INT_VECTOR), .INT_ACK(INT_ACK), .STACK_FULL(STACK_FULL), .STACK_OVERFLOW(STACK_OVERFLOW));

// file: verification/psq_mem_model.sv
`timescale 1ns/10ps
module psq_mem_model #(
   parameter int PC_W    = 10,
   parameter int INSTR_W = 14
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // Fetch port
   input  wire logic [PC_W-1:0]    fetch_addr,
   input  wire logic               fetch_en,
   output logic      [INSTR_W-1:0] instr_data,
   // Interrupt requester
   input  wire logic               int_ack,
   output logic                    int_req,
   output logic      [PC_W-1:0]    int_vector
);
   // Word is only good in the fetch phase, so a late capture reads garbage
   assign instr_data = INSTR_W'(fetch_addr * 7 + 3) ^ {INSTR_W{!fetch_en}};

   always @(negedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_req    <= '0;
         int_vector <= '0;
      end else if (int_req) begin
         int_req <= !int_ack;
      end else begin
         // Vector is released while idle, so it changes every cycle
         int_req    <= $urandom_range(0, 5) == 0;
         int_vector <= PC_W'($urandom);
      end
   end
endmodule : psq_mem_model

// file: verification/test_program_sequencer_stack.sv
`timescale 1ns/10ps
module test_program_sequencer_stack
   import psq_pkg::*;
;
   localparam int PC_W  = 10;
   localparam int DEPTH = 4;
   localparam int IW    = 14;
   logic            clock, rst_b, fetch_en, instr_valid, int_req, int_ack, stack_full, stack_overflow;
   logic [PC_W-1:0] fetch_addr, exec_addr, ctrl_target, int_vector;
   logic [IW-1:0]   instr_data, instr_word;
   logic [7:0]      ctrl_low_byte, pc_low_byte;
   psq_phase_t      phase;
   psq_op_t         ctrl_op;
   int              failures, num_checks, cycles, o;
   // Reference model: fetch address, executing address, valid flag, saved returns
   logic [PC_W-1:0] m_f, m_e, nf, stk[$];
   logic            m_v, nv, ack, ovf;

   psq_sequencer #(.PC_W(PC_W), .DEPTH(DEPTH), .INSTR_W(IW)) i_psq_sequencer (.CLOCK(clock), .RST_B(rst_b),
      .FETCH_ADDR(fetch_addr), .FETCH_EN(fetch_en), .INSTR_DATA(instr_data), .PHASE(phase), .INSTR_WORD(instr_word),
      .INSTR_VALID(instr_valid), .EXEC_ADDR(exec_addr), .CTRL_OP(ctrl_op), .CTRL_TARGET(ctrl_target),
      .CTRL_LOW_BYTE(ctrl_low_byte), .PC_LOW_BYTE(pc_low_byte), .INT_REQ(int_req), .INT_VECTOR(int_vector),
      .INT_ACK(int_ack), .STACK_FULL(stack_full), .STACK_OVERFLOW(stack_overflow));
   psq_mem_model #(.PC_W(PC_W), .INSTR_W(IW)) i_psq_mem_model (.clk(clock), .rst_b(rst_b), .fetch_addr(fetch_addr),
      .fetch_en(fetch_en), .instr_data(instr_data), .int_ack(int_ack), .int_req(int_req), .int_vector(int_vector));

   initial begin
      clock = '0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk

   task automatic conclude;
      if (failures == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   task automatic do_reset;
      rst_b = '0;
      repeat (20) @(negedge clock);
      {m_f, m_e, m_v} = '0;
      stk = {};
      chk("fetch_addr", 0, fetch_addr);
      chk("stack_full", 0, stack_full);
      rst_b = '1;
   endtask : do_reset

   task automatic run(input int n);
      for (int k = 0; k < n; k++) begin
         do @(negedge clock); while (phase !== PSQ_T4);
         o = $urandom_range(0, 7);
         // Calls dominate early in each block of 100 so the stack fills and overflows
         if ((o == 3 || o == 4) && (k % 100 < 40 || stk.size() == 0)) o = 2;
         ctrl_op = psq_op_t'(o);
         ctrl_target = PC_W'($urandom);
         ctrl_low_byte = 8'($urandom);
         #1;
         if (!m_v || o == 7) o = 0;
         {nv, ack, ovf} = '0;
         nf = m_f + 1'b1;
         case (o)
            0: if (int_req && stk.size() < DEPTH) begin
               stk.push_back(m_f);
               {nf, ack} = {int_vector, 1'b1};
            end else begin
               nv = '1;
            end
            1: nf = ctrl_target;
            2: begin
               if (stk.size() == DEPTH) begin
                  void'(stk.pop_front());
                  ovf = '1;
               end
               stk.push_back(m_f);
               nf = ctrl_target;
            end
            3, 4: nf = stk.pop_back();
            6: nf = {m_e[PC_W-1:8], ctrl_low_byte};
            default: ;
         endcase
         {m_e, m_f, m_v} = {m_f, nf, nv};
         @(negedge clock);
         chk("fetch_addr", m_f, fetch_addr);
         chk("instr_valid", m_v, instr_valid);
         chk("int_ack", ack, int_ack);
         chk("stack_full", stk.size() == DEPTH, stack_full);
         chk("stack_overflow", ovf, stack_overflow);
         if (m_v) begin
            chk("exec_addr", m_e, exec_addr);
            chk("pc_low_byte", m_e[7:0], pc_low_byte);
            chk("instr_word", IW'(m_e * 7 + 3), instr_word);
         end
      end
   endtask : run

   initial begin
      {rst_b, ctrl_target, ctrl_low_byte} = '0;
      ctrl_op = PSQ_OP_NONE;
      void'($urandom(32'h8A85));
      // Second pass resets in mid-run with the stack still holding returns
      repeat (2) begin
         do_reset();
         run(400);
      end
      conclude();
   end
endmodule : test_program_sequencer_stack
